// ===== rtl/tlb_address_translation.sv
// Summary of operation
// R1 - 64 entries compared all at once.
// R2 - Valid permitted match gives hit and translation.
// R3 - Protection violation on match raises fault.
// R4 - No valid match starts a table walk.
// R5 - Walk visits context, level one, two, three.
// R6 - Context entry from base plus context number.
// R7 - Descriptor ends walk; pointer selects next entry.
// R8 - Fault after level three or invalid entry.
// R9 - Found descriptor refills entry, retries translation.
// R10 - Tag holds page bits 31:12 and context.
// R11 - Data holds page number, flags, protection, size.
// R12 - Low twelve address bits pass unchanged.
// R13 - Size code selects 4K to 4G region.
// R14 - Size code chooses which index fields compare.
// R15 - Page number bits used depend on size.
// R16 - Cacheable flag drives bus bit 43.
// R17 - Writes through an entry set modified flag.
// R18 - Reset and flush clear valid flags.
// R19 - Software must avoid overlapping loaded entries.
// R20 - Recheck for hit before storing walked entry.
// R21 - Protection code gives user and supervisor rights.
// R22 - Supervisor codes 6, 7 skip context compare.
// R23 - Replacement pointer picks entry, written at once.
`timescale 1ns/1ps
`default_nettype none
module tlb_address_translation
  import tlb_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic mmuEnable,
  input wire logic xlateValid,
  input wire xlate_req_t xlateReq,
  input wire logic [21:0] ctxTableBase,
  input wire logic flushEntry,
  input wire logic [5:0] flushIndex,
  input wire logic flushAll,
  input wire logic busAddrPhase,
  output logic memReqValid,
  output logic [35:0] memReqAddr,
  input wire logic memReqReady,
  input wire logic memRspValid,
  input wire logic [31:0] memRspData,
  output logic xlateDone,
  output logic xlateHit,
  output logic xlateFault,
  output logic walkFault,
  output logic [35:0] physAddr,
  output logic cacheableBusBit
);

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_WAIT, S_REFILL} state_t;

  // Entry storage; only the valid and modified flags need a reset value.
  tlb_tag_t tags_r [TLB_ENTRIES];
  tlb_data_t data_r [TLB_ENTRIES];
  logic [TLB_ENTRIES-1:0] validVec_r, validVec_nxt;
  logic [TLB_ENTRIES-1:0] modVec_r, modVec_nxt;

  state_t state_r, state_nxt;
  logic [1:0] level_r, level_nxt;
  logic [35:0] memReqAddr_r, memReqAddr_nxt;
  tlb_data_t walkData_r, walkData_nxt;
  logic walkMod_r, walkMod_nxt;
  logic [5:0] replPtr_r, replPtr_nxt;
  logic xlateDone_r, xlateDone_nxt;
  logic xlateHit_r, xlateHit_nxt;
  logic xlateFault_r, xlateFault_nxt;
  logic walkFault_r, walkFault_nxt;
  logic [35:0] physAddr_r, physAddr_nxt;
  logic cacheable_r, cacheable_nxt;

  logic [TLB_ENTRIES-1:0] matchVec;
  logic anyMatch, reqLive;
  logic [5:0] hitIdx;
  tlb_data_t hitData;
  logic allowed;
  logic [35:0] hitPhys;
  logic refillWe;
  logic [1:0] rspType;
  logic [7:0] nextIndex;
  logic [35:0] ptrBase;
  tlb_tag_t reqTag;

  assign reqTag = '{virtualPage: xlateReq.virtualAddr[31:12],
                    contextNumber: xlateReq.contextNumber};

  // All entries compare in parallel against the request.
  generate
    for (genvar e = 0; e < TLB_ENTRIES; e++) begin : g_cam // R1
      tlb_entry_match u_match (
        .entryTag(tags_r[e]),
        .regionSizeCode(data_r[e].regionSizeCode),
        .protectionCode(data_r[e].protectionCode),
        .entryValid(validVec_r[e]),
        .reqTag(reqTag),
        .supervisor(xlateReq.supervisor),
        .match(matchVec[e])
      );
    end
  endgenerate

  // Lowest matching index wins; overlapping entries give an undefined mapping.
  always_comb begin
    hitIdx = 6'h00;
    for (int i = TLB_ENTRIES - 1; i >= 0; i--) begin
      if (matchVec[i]) begin
        hitIdx = i[5:0];
      end
    end
    anyMatch = |matchVec;
    reqLive = xlateValid && !xlateDone_r;
    hitData = data_r[hitIdx];
    allowed = accessAllowed(hitData.protectionCode, xlateReq.supervisor,
                            xlateReq.write, xlateReq.execute); // R21
  end

  tlb_phys_addr u_phys (
    .physicalPageNumber(hitData.physicalPageNumber),
    .regionSizeCode(hitData.regionSizeCode),
    .virtualAddr(xlateReq.virtualAddr),
    .physAddr(hitPhys)
  );

  always_comb begin
    rspType = memRspData[1:0];
    ptrBase = {memRspData[31:TABLE_PTR_LSB], 6'h00};
    case (level_r)
      LEVEL_CTX: nextIndex = xlateReq.virtualAddr[31:24];
      LEVEL_ONE: nextIndex = {2'h0, xlateReq.virtualAddr[23:18]};
      default: nextIndex = {2'h0, xlateReq.virtualAddr[17:12]};
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    level_nxt = level_r;
    memReqAddr_nxt = memReqAddr_r;
    walkData_nxt = walkData_r;
    walkMod_nxt = walkMod_r;
    xlateDone_nxt = 1'b0;
    xlateHit_nxt = 1'b0;
    xlateFault_nxt = 1'b0;
    walkFault_nxt = 1'b0;
    physAddr_nxt = physAddr_r;
    cacheable_nxt = cacheable_r;
    refillWe = 1'b0;
    memReqValid = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (reqLive && !mmuEnable) begin
          xlateDone_nxt = 1'b1;
          xlateHit_nxt = 1'b1;
          physAddr_nxt = {4'h0, xlateReq.virtualAddr};
          cacheable_nxt = 1'b0;
        end else if (reqLive && anyMatch && allowed) begin
          xlateDone_nxt = 1'b1; // R2
          xlateHit_nxt = 1'b1;
          physAddr_nxt = hitPhys; // R12
          cacheable_nxt = hitData.cacheable;
        end else if (reqLive && anyMatch) begin
          xlateDone_nxt = 1'b1; // R3
          xlateFault_nxt = 1'b1;
        end else if (reqLive) begin
          // The walk is launched by hardware; software never sees the miss.
          state_nxt = S_FETCH; // R4 R9
          level_nxt = LEVEL_CTX;
          memReqAddr_nxt = {ctxTableBase, xlateReq.contextNumber, 2'h0}; // R6
        end
      end
      S_FETCH: begin
        memReqValid = 1'b1;
        if (memReqReady) begin
          state_nxt = S_WAIT;
        end
      end
      S_WAIT: begin
        if (memRspValid) begin
          if (rspType == DESC_PAGE) begin
            state_nxt = S_REFILL; // R7
            walkData_nxt.physicalPageNumber = memRspData[31:DESC_PPN_LSB];
            walkData_nxt.cacheable = memRspData[DESC_CACHE_BIT];
            walkData_nxt.protectionCode = memRspData[DESC_PROT_LSB +: 3];
            // Level 0 to 3 map to size codes 11 down to 00.
            walkData_nxt.regionSizeCode = ~level_r; // R13
            walkMod_nxt = memRspData[DESC_MOD_BIT];
          end else if (rspType == DESC_TABLE_PTR && level_r != LEVEL_LAST) begin
            state_nxt = S_FETCH; // R5 R7
            level_nxt = level_r + 2'h1;
            memReqAddr_nxt = ptrBase + {26'h0, nextIndex, 2'h0};
          end else begin
            state_nxt = S_IDLE; // R8
            xlateDone_nxt = 1'b1;
            xlateFault_nxt = 1'b1;
            walkFault_nxt = 1'b1;
          end
        end
      end
      default: begin
        // A mapping that appeared during the walk is kept, not duplicated.
        refillWe = !anyMatch; // R20 R23
        state_nxt = S_IDLE; // R9
      end
    endcase
  end

  always_comb begin
    validVec_nxt = validVec_r;
    modVec_nxt = modVec_r;
    replPtr_nxt = replPtr_r + 6'h01;
    if (flushAll) begin
      validVec_nxt = '0; // R18
    end else if (flushEntry) begin
      validVec_nxt[flushIndex] = 1'b0; // R18
    end
    // A refill in the same cycle as a flush still lands its entry.
    if (refillWe) begin
      validVec_nxt[replPtr_r] = 1'b1; // R9 R23
      modVec_nxt[replPtr_r] = walkMod_r;
    end
    if (state_r == S_IDLE && reqLive && mmuEnable && anyMatch && allowed &&
        xlateReq.write) begin
      modVec_nxt[hitIdx] = 1'b1; // R17
    end
  end

  always_ff @(posedge clk) begin
    if (refillWe) begin
      tags_r[replPtr_r] <= reqTag; // R10 R23
      data_r[replPtr_r] <= walkData_r; // R11 R23
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      level_r <= LEVEL_CTX;
      memReqAddr_r <= PHYS_RESET;
      walkData_r <= '0;
      walkMod_r <= 1'b0;
      replPtr_r <= REPL_RESET;
      validVec_r <= '0; // R18
      modVec_r <= '0;
      xlateDone_r <= 1'b0;
      xlateHit_r <= 1'b0;
      xlateFault_r <= 1'b0;
      walkFault_r <= 1'b0;
      physAddr_r <= PHYS_RESET;
      cacheable_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      level_r <= level_nxt;
      memReqAddr_r <= memReqAddr_nxt;
      walkData_r <= walkData_nxt;
      walkMod_r <= walkMod_nxt;
      replPtr_r <= replPtr_nxt;
      validVec_r <= validVec_nxt;
      modVec_r <= modVec_nxt;
      xlateDone_r <= xlateDone_nxt;
      xlateHit_r <= xlateHit_nxt;
      xlateFault_r <= xlateFault_nxt;
      walkFault_r <= walkFault_nxt;
      physAddr_r <= physAddr_nxt;
      cacheable_r <= cacheable_nxt;
    end
  end

  assign memReqAddr = memReqAddr_r;
  assign xlateDone = xlateDone_r;
  assign xlateHit = xlateHit_r;
  assign xlateFault = xlateFault_r;
  assign walkFault = walkFault_r;
  assign physAddr = physAddr_r;
  // Gated by the phase so the bit never leaks into data cycles.
  assign cacheableBusBit = mmuEnable && busAddrPhase && cacheable_r; // R16

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  walk_start_a: assert property ( // R4
    state_r == S_IDLE && reqLive && mmuEnable && !anyMatch
    |=> state_r == S_FETCH && memReqValid && level_r == LEVEL_CTX
  ) else $error("Miss did not start a table walk.");

  ctx_address_a: assert property ( // R6
    state_r == S_IDLE && reqLive && mmuEnable && !anyMatch
    |=> memReqAddr == {$past(ctxTableBase), $past(xlateReq.contextNumber), 2'h0}
  ) else $error("Context table address is wrong.");

  hit_done_a: assert property ( // R2
    state_r == S_IDLE && reqLive && mmuEnable && anyMatch && allowed
    |=> xlateDone && xlateHit && !xlateFault && physAddr == $past(hitPhys)
  ) else $error("Permitted hit was not translated.");

  prot_fault_a: assert property ( // R3
    state_r == S_IDLE && reqLive && mmuEnable && anyMatch && !allowed
    |=> xlateDone && xlateFault && !xlateHit && state_r == S_IDLE
  ) else $error("Protection violation did not fault.");

  page_offset_a: assert property ( // R12
    xlateHit |-> physAddr[11:0] == $past(xlateReq.virtualAddr[11:0])
  ) else $error("Page offset was altered.");

  walk_depth_a: assert property ( // R8
    state_r == S_WAIT && memRspValid && level_r == LEVEL_LAST && rspType != DESC_PAGE
    |=> xlateFault && walkFault && state_r == S_IDLE
  ) else $error("Walk past level three did not fault.");

  walk_descend_a: assert property ( // R7
    state_r == S_WAIT && memRspValid && rspType == DESC_TABLE_PTR && level_r != LEVEL_LAST
    |=> state_r == S_FETCH && level_r == $past(level_r) + 2'h1
  ) else $error("Table pointer did not descend one level.");

  refill_entry_a: assert property ( // R9
    state_r == S_REFILL && !anyMatch
    |=> validVec_r[$past(replPtr_r)] && state_r == S_IDLE
  ) else $error("Walked descriptor was not stored.");

  refill_skip_a: assert property ( // R20
    state_r == S_REFILL && anyMatch && !flushAll && !flushEntry
    |=> validVec_r == $past(validVec_r)
  ) else $error("Refill duplicated an existing mapping.");

  flush_clear_a: assert property ( // R18
    flushAll && !refillWe |=> validVec_r == '0
  ) else $error("Flush left an entry valid.");

  modify_set_a: assert property ( // R17
    state_r == S_IDLE && reqLive && mmuEnable && anyMatch && allowed && xlateReq.write
    |=> modVec_r[$past(hitIdx)]
  ) else $error("Write hit did not set the modified flag.");

  bus_bit_a: assert property ( // R16
    state_r == S_IDLE && reqLive && mmuEnable && anyMatch && allowed && busAddrPhase
    |=> !mmuEnable || !busAddrPhase || cacheableBusBit == $past(hitData.cacheable)
  ) else $error("Cacheable bit does not follow the hit entry.");
endmodule : tlb_address_translation
`default_nettype wire

// ===== shared/tlb_pkg.sv
package tlb_pkg;

  localparam int TLB_ENTRIES = 64;
  localparam int TLB_IDX_W = 6;

  // Descriptor type field, bits 1:0 of every table word.
  localparam logic [1:0] DESC_INVALID = 2'h0;
  localparam logic [1:0] DESC_TABLE_PTR = 2'h1;
  localparam logic [1:0] DESC_PAGE = 2'h2;
  localparam logic [1:0] DESC_RESERVED = 2'h3;

  // Field positions inside page descriptor and table pointer words.
  localparam int DESC_PPN_LSB = 8;
  localparam int DESC_CACHE_BIT = 7;
  localparam int DESC_MOD_BIT = 6;
  localparam int DESC_PROT_LSB = 2;
  localparam int TABLE_PTR_LSB = 2;

  // Walk levels: context table, then level one to level three.
  localparam logic [1:0] LEVEL_CTX = 2'h0;
  localparam logic [1:0] LEVEL_ONE = 2'h1;
  localparam logic [1:0] LEVEL_LAST = 2'h3;

  // Region size codes.
  localparam logic [1:0] REGION_4K = 2'h0;
  localparam logic [1:0] REGION_256K = 2'h1;
  localparam logic [1:0] REGION_16M = 2'h2;
  localparam logic [1:0] REGION_4G = 2'h3;

  // Protection codes 6 and 7 share these upper bits.
  localparam logic [1:0] PROT_KERNEL_HI = 2'h3;

  // Values after reset.
  localparam logic [5:0] REPL_RESET = 6'h00;
  localparam logic [35:0] PHYS_RESET = 36'h0;

  typedef struct packed {
    logic [19:0] virtualPage;
    logic [11:0] contextNumber;
  } tlb_tag_t;

  typedef struct packed {
    logic [23:0] physicalPageNumber;
    logic cacheable;
    logic [2:0] protectionCode;
    logic [1:0] regionSizeCode;
  } tlb_data_t;

  typedef struct packed {
    logic [31:0] virtualAddr;
    logic [11:0] contextNumber;
    logic supervisor;
    logic write;
    logic execute;
  } xlate_req_t;

  // Returns whether the access kind is allowed by a protection code.
  function automatic logic accessAllowed(input logic [2:0] protectionCode,
                                         input logic supervisor,
                                         input logic write,
                                         input logic execute);
    logic [2:0] rwx;
    rwx = 3'h0;
    case (protectionCode)
      3'h0: rwx = 3'h4;
      3'h1: rwx = 3'h6;
      3'h2: rwx = 3'h5;
      3'h3: rwx = 3'h7;
      3'h4: rwx = 3'h1;
      3'h5: rwx = supervisor ? 3'h6 : 3'h4;
      3'h6: rwx = supervisor ? 3'h5 : 3'h0;
      default: rwx = supervisor ? 3'h7 : 3'h0;
    endcase
    if (execute) begin
      return rwx[0];
    end else if (write) begin
      return rwx[1];
    end
    return rwx[2];
  endfunction : accessAllowed

endpackage : tlb_pkg

// ===== rtl/tlb_entry_match.sv
`timescale 1ns/1ps
`default_nettype none
module tlb_entry_match
  import tlb_pkg::*;
(
  input wire tlb_tag_t entryTag,
  input wire logic [1:0] regionSizeCode,
  input wire logic [2:0] protectionCode,
  input wire logic entryValid,
  input wire tlb_tag_t reqTag,
  input wire logic supervisor,
  output logic match
);

  logic ctxOk;
  logic idx1Ok;
  logic idx2Ok;
  logic idx3Ok;

  always_comb begin
    // Kernel mappings hit in every context for supervisor accesses.
    ctxOk = (entryTag.contextNumber == reqTag.contextNumber) ||
            (supervisor && protectionCode[2:1] == PROT_KERNEL_HI); // R22
    idx1Ok = (regionSizeCode == REGION_4G) ||
             (entryTag.virtualPage[19:12] == reqTag.virtualPage[19:12]); // R14
    idx2Ok = (regionSizeCode[1]) ||
             (entryTag.virtualPage[11:6] == reqTag.virtualPage[11:6]); // R14
    idx3Ok = (regionSizeCode != REGION_4K) ||
             (entryTag.virtualPage[5:0] == reqTag.virtualPage[5:0]); // R14
    match = entryValid && ctxOk && idx1Ok && idx2Ok && idx3Ok; // R2
  end

endmodule : tlb_entry_match
`default_nettype wire

// ===== rtl/tlb_phys_addr.sv
`timescale 1ns/1ps
`default_nettype none
module tlb_phys_addr
  import tlb_pkg::*;
(
  input wire logic [23:0] physicalPageNumber,
  input wire logic [1:0] regionSizeCode,
  input wire logic [31:0] virtualAddr,
  output logic [35:0] physAddr
);

  always_comb begin
    case (regionSizeCode) // R13
      REGION_4K: physAddr = {physicalPageNumber, virtualAddr[11:0]}; // R12 R15
      REGION_256K: physAddr = {physicalPageNumber[23:6], virtualAddr[17:0]}; // R15
      REGION_16M: physAddr = {physicalPageNumber[23:12], virtualAddr[23:0]}; // R15
      default: physAddr = {physicalPageNumber[23:20], virtualAddr}; // R15
    endcase
  end

endmodule : tlb_phys_addr
`default_nettype wire

// ===== verification/tlb_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module tlb_mem_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic memReqValid,
  input wire logic [35:0] memReqAddr,
  output logic memReqReady,
  output logic memRspValid,
  output logic [31:0] memRspData
);
  // An address never written reads as an invalid descriptor, like cleared table memory.
  logic [31:0] words [logic [35:0]];
  logic [35:0] reqLog [$];
  int stall = 0;
  int lat = 1;
  int waitCnt;
  int rspCnt;
  logic [31:0] rspWord;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memReqReady <= 1'b0;
      memRspValid <= 1'b0;
      memRspData <= 32'h0;
      waitCnt = 0;
      rspCnt = 0;
    end else begin
      memRspValid <= 1'b0;
      // Data outside a response toggles so a stale word can never pass for a fresh one.
      memRspData <= ~memRspData;
      if (memReqValid && memReqReady) begin
        reqLog.push_back(memReqAddr);
        rspWord = words.exists(memReqAddr) ? words[memReqAddr] : 32'h0;
        memReqReady <= 1'b0;
        rspCnt = lat;
        waitCnt = 0;
      end else if (memReqValid && rspCnt == 0) begin
        if (waitCnt >= stall) begin
          memReqReady <= 1'b1;
        end
        waitCnt++;
      end
      if (rspCnt > 0) begin
        rspCnt--;
        if (rspCnt == 0) begin
          memRspValid <= 1'b1;
          memRspData <= rspWord;
        end
      end
    end
  end
endmodule : tlb_mem_model
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb;
  import tlb_pkg::*;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic mmuEnable = 1'b1;
  logic xlateValid = 1'b0;
  xlate_req_t xlateReq = '0;
  logic [21:0] ctxTableBase = 22'h2a5c1;
  logic flushEntry = 1'b0;
  logic [5:0] flushIndex = 6'h00;
  logic flushAll = 1'b0;
  logic busAddrPhase = 1'b1;
  logic memReqValid, memReqReady, memRspValid, xlateDone, xlateHit, xlateFault, walkFault;
  logic cacheableBusBit, hit, flt, wflt;
  logic [35:0] memReqAddr, physAddr;
  logic [31:0] memRspData;
  logic [35:0] expAddr [$];
  int miscompares = 0;
  int testsRun = 0;
  // Rights per protection code: user read, write, execute, then supervisor read, write, execute.
  logic [5:0] rights [8] = '{6'h24, 6'h36, 6'h2d, 6'h3f, 6'h09, 6'h26, 6'h05, 6'h07};

  always #12.5 clk = ~clk;

  tlb_address_translation DUT (.clk(clk), .sys_rst(sysRst), .mmuEnable(mmuEnable),
    .xlateValid(xlateValid), .xlateReq(xlateReq), .ctxTableBase(ctxTableBase),
    .flushEntry(flushEntry), .flushIndex(flushIndex), .flushAll(flushAll),
    .busAddrPhase(busAddrPhase), .memReqValid(memReqValid), .memReqAddr(memReqAddr),
    .memReqReady(memReqReady), .memRspValid(memRspValid), .memRspData(memRspData),
    .xlateDone(xlateDone), .xlateHit(xlateHit), .xlateFault(xlateFault),
    .walkFault(walkFault), .physAddr(physAddr), .cacheableBusBit(cacheableBusBit));

  tlb_mem_model mem (.clk(clk), .sys_rst(sysRst), .memReqValid(memReqValid),
    .memReqAddr(memReqAddr), .memReqReady(memReqReady), .memRspValid(memRspValid),
    .memRspData(memRspData));

  task automatic finalReport();
    if (miscompares == 0 && testsRun > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finalReport

  function automatic logic [31:0] pageWord(input logic [23:0] physical_page_number, input logic c,
                                           input logic [2:0] prot);
    return {physical_page_number, c, 2'h0, prot, DESC_PAGE};
  endfunction : pageWord

  function automatic logic [35:0] expPhys(input logic [23:0] physical_page_number, input int l,
                                          input logic [31:0] va);
    logic [35:0] m;
    m = (36'h1 << ((l == 0) ? 32 : 30 - 6 * l)) - 36'h1;
    return ({physical_page_number, 12'h0} & ~m) | ({4'h0, va} & m);
  endfunction : expPhys

  // Each path gets private tables so that walks of different tests never share a word.
  task automatic mapPath(input int sn, input logic [31:0] va, input logic [11:0] ctx,
                         input int lvl, input logic [31:0] leaf);
    logic [35:0] a;
    logic [35:0] b;
    logic [7:0] ix [4];
    ix = '{8'h0, va[31:24], {2'h0, va[23:18]}, {2'h0, va[17:12]}};
    a = {ctxTableBase, ctx, 2'h0};
    for (int i = 0; i <= lvl; i++) begin
      b = 36'h8_0000_0000 + 36'(sn) * 36'h4000 + 36'(i) * 36'h1000;
      mem.words[a] = (i == lvl) ? leaf : {b[35:6], DESC_TABLE_PTR};
      expAddr.push_back(a);
      if (i < 3) a = b + {26'h0, ix[i + 1], 2'h0};
    end
  endtask : mapPath

  task automatic xlate(input logic [31:0] va, input logic [11:0] ctx, input logic [2:0] kind);
    int n;
    @(posedge clk);
    xlateReq <= '{va, ctx, kind[2], kind[1], kind[0]};
    xlateValid <= 1'b1;
    for (n = 0; n < 300; n++) begin
      @(posedge clk);
      if (xlateDone === 1'b1) break;
    end
    // Released at the edge that sees done; the design ignores the request in that cycle.
    xlateValid <= 1'b0;
    hit = xlateHit;
    flt = xlateFault;
    wflt = walkFault;
    if (n == 300) begin
      miscompares++;
      finalReport();
    end
  endtask : xlate

  task automatic checkLog();
    `CHK("walk reads", expAddr.size(), mem.reqLog.size())
    if (expAddr.size() == mem.reqLog.size())
      foreach (expAddr[i]) `CHK("walk address", expAddr[i], mem.reqLog[i])
    expAddr.delete();
    mem.reqLog.delete();
  endtask : checkLog

  task automatic testSizes();
    logic [31:0] va;
    logic [11:0] ctx;
    logic [23:0] physical_page_number;
    int vb;
    for (int l = 0; l < 4; l++) begin
      va = 32'h5a96_c3e1 + 32'(l) * 32'h0104_1000;
      ctx = 12'h100 + 12'(l);
      physical_page_number = 24'hb7e4d2 - 24'(l);
      vb = (l == 0) ? 32 : 30 - 6 * l;
      mapPath(l, va, ctx, l, pageWord(physical_page_number, l[0], 3'h3));
      xlate(va, ctx, 3'h4);
      `CHK("refill hit", 1'b1, hit)
      `CHK("physical address", expPhys(physical_page_number, l, va), physAddr)
      `CHK("cacheable bit", l[0], cacheableBusBit)
      checkLog();
      va = va ^ (32'h1 << (vb - 1));
      xlate(va, ctx, 3'h4);
      `CHK("region hit", 1'b1, hit)
      `CHK("region address", expPhys(physical_page_number, l, va), physAddr)
      checkLog();
      if (l == 0) ctx = ctx + 12'h1;
      else va = va ^ (32'h1 << vb);
      xlate(va, ctx, 3'h4);
      `CHK("outside region", 1'b1, wflt)
      mem.reqLog.delete();
    end
  endtask : testSizes

  task automatic testFaults();
    logic [31:0] leaf [4] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_0000, 32'h0001_2341};
    mem.stall = 3;
    mem.lat = 4;
    for (int l = 0; l < 4; l++) begin
      mapPath(8 + l, 32'h3c5a_7e00 + 32'(l), 12'h300 + 12'(l), l, leaf[l]);
      xlate(32'h3c5a_7e00 + 32'(l), 12'h300 + 12'(l), 3'h0);
      `CHK("walk fault", 3'h3, {hit, flt, wflt})
      checkLog();
    end
    mem.stall = 0;
    mem.lat = 1;
  endtask : testFaults

  task automatic testProtection();
    logic [2:0] kinds [6] = '{3'h0, 3'h2, 3'h1, 3'h4, 3'h6, 3'h5};
    logic [31:0] va;
    logic ok;
    for (int c = 0; c < 8; c++) begin
      va = 32'hc012_3456 + 32'(c) * 32'h0100_0000;
      mapPath(16 + c, va, 12'h200, 3, pageWord(24'h0f1e2d + 24'(c), 1'b0, c[2:0]));
      for (int k = 0; k < 6; k++) begin
        ok = rights[c][(kinds[k][2] ? 0 : 3) + (kinds[k][0] ? 0 : (kinds[k][1] ? 1 : 2))];
        xlate(va, 12'h200, kinds[k]);
        `CHK("access result", {ok, !ok, 1'b0}, {hit, flt, wflt})
      end
      checkLog();
      xlate(va, 12'h3ff, 3'h4);
      `CHK("kernel context", (c >= 6), hit)
      mem.reqLog.delete();
    end
  endtask : testProtection

  task automatic testFlush();
    for (int m = 0; m < 4; m++) begin
      mapPath(30, 32'h7711_2233, 12'h050, 3, pageWord(24'h334455, 1'b1, 3'h1));
      xlate(32'h7711_2233, 12'h050, 3'h6);
      `CHK("flushed refill", 2'h3, {hit, cacheableBusBit})
      checkLog();
      xlate(32'h7711_2233, 12'h050, 3'h6);
      checkLog();
      if (m == 3) break;
      if (m == 1) begin
        for (int i = 0; i < 64; i++) begin
          @(posedge clk);
          flushEntry <= 1'b1;
          flushIndex <= 6'(i);
        end
      end else begin
        @(posedge clk);
        flushAll <= (m == 0);
        sysRst <= (m == 2);
      end
      @(posedge clk);
      flushAll <= 1'b0;
      flushEntry <= 1'b0;
      sysRst <= 1'b0;
      if (m == 2) `CHK("reset outputs", 39'h0, {xlateDone, xlateHit, xlateFault, physAddr})
    end
  endtask : testFlush

  task automatic testDisabled();
    @(posedge clk);
    busAddrPhase <= 1'b0;
    @(negedge clk);
    `CHK("address phase gate", 1'b0, cacheableBusBit)
    @(posedge clk);
    busAddrPhase <= 1'b1;
    mmuEnable <= 1'b0;
    xlate(32'hdead_0123, 12'h7ff, 3'h2);
    `CHK("bypass address", {1'b1, 4'h0, 32'hdead_0123}, {hit, physAddr})
    `CHK("bypass cacheable", 1'b0, cacheableBusBit)
    checkLog();
    @(posedge clk);
    mmuEnable <= 1'b1;
  endtask : testDisabled

  initial begin
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    testSizes();
    testFaults();
    testProtection();
    testFlush();
    testDisabled();
    finalReport();
  end
endmodule : tb
`default_nettype wire
